// ==== hw/fpm_power_ctrl.sv ====
`timescale 1ns/1ns
// Overview of operation
// - only an executed deep-sleep command enters deep sleep.
// - in deep sleep every command except wake is ignored.
// - select high with no internal cycle gives ordinary standby, not sleep.
// - power-up always lands in standby with write-enable latch cleared.
// - deep-sleep executes only if select rises right after eighth bit.
// - sleep is counted only after a fixed entry delay from select rise.
// - deep-sleep during an internal cycle is rejected, cycle unaffected.
// - wake with extra clocks while selected is rejected.
// - valid wake returns to standby after wake delay; host stays deselected.
// - wake during an internal cycle is rejected, cycle unaffected.
// - under power-on reset logic is held reset and nothing answers.
// - after reset, write-class commands are ignored for the inhibit interval.
// - delivered array reads erased bytes and status bits read zero.
// - cycle-active flag is one for a whole internal cycle, then zero.
module fpm_power_ctrl
	import fpm_pkg::*;
#(
	parameter logic [7:0] SLEEP_CODE  = FPM_CMD_SLEEP_DEF,
	parameter logic [7:0] WAKE_CODE   = FPM_CMD_WAKE_DEF,
	parameter int         INHIBIT_CYC = FPM_INHIBIT_CYC,
	parameter int         ENTRY_CYC   = FPM_ENTRY_CYC,
	parameter int         WAKE_CYC    = FPM_WAKE_CYC
)
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       chip_select_n,
	input  wire logic       serial_clock,
	input  wire logic       serial_data_in,
	input  wire logic       cycle_start,
	input  wire logic       cycle_done,
	input  wire logic       write_latch_set,
	input  wire logic       write_latch_clear,
	output logic            deep_sleep,
	output logic            standby,
	output logic            write_inhibit,
	output logic            write_class_ok,
	output logic            cmd_accept,
	output logic [7:0]      status_byte,
	output logic [7:0]      erased_value,
	output logic            cycle_active_flag,
	output logic            write_enable_latch
);
	// pin synchronisers: first stage feeds only the second
	logic [1:0] cs_sync;
	logic [1:0] sck_sync;
	logic [1:0] sdi_sync;
	logic       cs_q;
	logic       sck_q;
	logic       cs_n;
	logic       sck;
	logic       sdi;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cs_sync  <= 2'h3;
			sck_sync <= 2'h0;
			sdi_sync <= 2'h0;
			cs_q     <= 1'b1;
			sck_q    <= 1'b0;
		end
		else
		begin
			cs_sync  <= {cs_sync[0], chip_select_n};
			sck_sync <= {sck_sync[0], serial_clock};
			sdi_sync <= {sdi_sync[0], serial_data_in};
			cs_q     <= cs_sync[1];
			sck_q    <= sck_sync[1];
		end
	end

	assign cs_n = cs_sync[1];
	assign sck  = sck_sync[1];
	assign sdi  = sdi_sync[1];

	logic sck_rise;
	logic cs_rise;
	assign sck_rise = sck & ~sck_q & ~cs_n;
	assign cs_rise  = cs_n & ~cs_q;

	// shifter: counts bits while selected, saturates at fifteen
	logic [7:0]             shreg;
	logic [FPM_BIT_CNT_W-1:0] bits;
	logic [7:0]             next_shreg;
	logic [FPM_BIT_CNT_W-1:0] next_bits;

	always_comb
	begin
		next_shreg = shreg;
		next_bits  = bits;
		if (cs_n)
			next_bits = '0;
		else if (sck_rise)
		begin
			next_shreg = {shreg[6:0], sdi};
			if (bits != 4'hF)
				next_bits = bits + 4'h1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			shreg <= 8'h00;
			bits  <= '0;
		end
		else
		begin
			shreg <= next_shreg;
			bits  <= next_bits;
		end
	end

	fpm_cmd_t frame;
	assign frame.valid = cs_rise & (bits == 4'h8);
	assign frame.code  = shreg;

	// mode machine and delay counter
	fpm_mode_t            mode;
	fpm_mode_t            next_mode;
	logic [FPM_CNT_W-1:0] dly;
	logic [FPM_CNT_W-1:0] next_dly;
	logic [FPM_CNT_W-1:0] inh;
	logic [FPM_CNT_W-1:0] next_inh;
	logic                 busy;
	logic                 next_busy;
	logic                 wr_latch;
	logic                 next_wr_latch;
	logic                 is_sleep;
	logic                 is_wake;
	logic                 is_write_cls;

	assign is_sleep     = frame.valid & (frame.code == SLEEP_CODE);
	assign is_wake      = frame.valid & (frame.code == WAKE_CODE);
	assign is_write_cls = (frame.code == FPM_CMD_SET_LATCH) | (frame.code == FPM_CMD_REWRITE)
		| (frame.code == FPM_CMD_BURN) | (frame.code == FPM_CMD_PG_CLEAR)
		| (frame.code == FPM_CMD_SEC_CLEAR);

	always_comb
	begin
		next_mode = mode;
		next_dly  = dly;
		next_inh  = (inh != '0) ? inh - 24'h1 : inh;
		next_busy = busy;
		next_wr_latch = wr_latch;
		if (cycle_start & ~busy)
			next_busy = 1'b1;
		else if (cycle_done)
			next_busy = 1'b0;
		if (write_latch_set & ~busy & (inh == '0) & (mode != FPM_SLEEP))
			next_wr_latch = 1'b1;
		else if (write_latch_clear)
			next_wr_latch = 1'b0;
		unique case (mode)
			FPM_STANDBY, FPM_ACTIVE:
			begin
				next_mode = cs_n ? FPM_STANDBY : FPM_ACTIVE;
				if (is_sleep & ~busy)
				begin
					next_mode = FPM_ENTERING;
					next_dly  = FPM_CNT_W'(ENTRY_CYC);
				end
			end
			FPM_ENTERING:
			begin
				next_dly = dly - 24'h1;
				if (dly <= 24'h1)
					next_mode = FPM_SLEEP;
			end
			FPM_SLEEP:
			begin
				// only the wake code is honoured; cycle_start still sets busy here
				if (is_wake & ~busy)
				begin
					next_mode = FPM_WAKING;
					next_dly  = FPM_CNT_W'(WAKE_CYC);
				end
			end
			FPM_WAKING:
			begin
				next_dly = dly - 24'h1;
				if (dly <= 24'h1)
					next_mode = FPM_STANDBY;
			end
			default:
				next_mode = FPM_STANDBY;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mode <= FPM_STANDBY;
			dly  <= '0;
			inh  <= FPM_CNT_W'(INHIBIT_CYC);
			busy <= 1'b0;
			wr_latch <= 1'b0;
		end
		else
		begin
			mode <= next_mode;
			dly  <= next_dly;
			inh  <= next_inh;
			busy <= next_busy;
			wr_latch <= next_wr_latch;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cmd_accept     <= 1'b0;
			write_class_ok <= 1'b0;
		end
		else
		begin
			// device entering, in or waking from deep sleep answers nothing else
			cmd_accept     <= frame.valid & (mode != FPM_SLEEP) & (mode != FPM_ENTERING)
				& (mode != FPM_WAKING);
			write_class_ok <= frame.valid & is_write_cls & (inh == '0) & ~busy
				& (mode == FPM_ACTIVE);
		end
	end

	assign deep_sleep         = (mode == FPM_SLEEP);
	assign standby            = (mode == FPM_STANDBY) & ~busy;
	assign write_inhibit      = (inh != '0);
	assign cycle_active_flag  = busy;
	assign write_enable_latch = wr_latch;
	assign status_byte        = {6'h00, wr_latch, busy};
	assign erased_value       = FPM_ERASED_BYTE;

	chk_sleep_entry: assert property (@(posedge clock) disable iff (rst)
		(mode != FPM_SLEEP) ##1 (mode == FPM_SLEEP) |-> $past(mode) == FPM_ENTERING)
		else $error("sleep entered without entry phase");
	chk_sleep_holds: assert property (@(posedge clock) disable iff (rst)
		(mode == FPM_SLEEP) && !is_wake |=> (mode == FPM_SLEEP))
		else $error("sleep left without wake");
	chk_busy_blocks: assert property (@(posedge clock) disable iff (rst)
		busy && is_sleep && (mode == FPM_ACTIVE) |=> mode != FPM_ENTERING)
		else $error("sleep accepted while busy");
	chk_wake_busy: assert property (@(posedge clock) disable iff (rst)
		busy && (mode == FPM_SLEEP) |=> mode == FPM_SLEEP)
		else $error("wake accepted while busy");
	chk_bad_frame: assert property (@(posedge clock) disable iff (rst)
		cs_rise && (bits != 4'h8) && (mode == FPM_ACTIVE) |=> mode != FPM_ENTERING)
		else $error("sleep on wrong bit count");
	chk_wake_time: assert property (@(posedge clock) disable iff (rst)
		$rose(mode == FPM_WAKING) |-> (mode == FPM_WAKING)[*2])
		else $error("wake delay too short");
	chk_inhibit_latch: assert property (@(posedge clock) disable iff (rst)
		(inh != '0) && !wr_latch |=> !wr_latch)
		else $error("latch set during inhibit");
	chk_reset_state: assert property (@(posedge clock)
		rst |=> (mode == FPM_STANDBY) && !wr_latch && !busy)
		else $error("bad post-reset state");
	chk_flag_cycle: assert property (@(posedge clock) disable iff (rst)
		cycle_done && !cycle_start |=> !cycle_active_flag)
		else $error("flag stays set after cycle");
	chk_entry_time: assert property (@(posedge clock) disable iff (rst)
		$rose(mode == FPM_ENTERING) |-> !deep_sleep [*2])
		else $error("sleep counted before entry delay");
	cov_sleep: cover property (@(posedge clock) disable iff (rst) $rose(deep_sleep));
	cov_wake: cover property (@(posedge clock) disable iff (rst) $rose(mode == FPM_WAKING));
	cov_reject: cover property (@(posedge clock) disable iff (rst) busy && is_sleep);
	cov_inhibit_end: cover property (@(posedge clock) disable iff (rst) $fell(write_inhibit));
endmodule

// ==== hw/fpm_pkg.sv ====
package fpm_pkg;
	// instruction codes and delays have no printed value; plain defaults
	localparam logic [7:0]  FPM_CMD_SLEEP_DEF  = 8'hB9;
	localparam logic [7:0]  FPM_CMD_WAKE_DEF   = 8'hAB;
	localparam logic [7:0]  FPM_CMD_SET_LATCH  = 8'h06;
	localparam logic [7:0]  FPM_CMD_REWRITE    = 8'h0A;
	localparam logic [7:0]  FPM_CMD_BURN       = 8'h02;
	localparam logic [7:0]  FPM_CMD_PG_CLEAR   = 8'hDB;
	localparam logic [7:0]  FPM_CMD_SEC_CLEAR  = 8'hD8;
	localparam int          FPM_CLK_MHZ        = 100;
	localparam int          FPM_ENTRY_NS       = 3000;
	localparam int          FPM_WAKE_NS        = 30000;
	localparam int          FPM_INHIBIT_US     = 1000;
	localparam int          FPM_ENTRY_CYC      = (FPM_ENTRY_NS * FPM_CLK_MHZ) / 1000;
	localparam int          FPM_WAKE_CYC       = (FPM_WAKE_NS * FPM_CLK_MHZ) / 1000;
	localparam int          FPM_INHIBIT_CYC    = FPM_INHIBIT_US * FPM_CLK_MHZ;
	localparam int          FPM_CNT_W          = 24;
	localparam logic [7:0]  FPM_ERASED_BYTE    = 8'hFF;
	localparam logic [7:0]  FPM_STATUS_RESET   = 8'h00;
	localparam int          FPM_BIT_CNT_W      = 4;

	typedef enum logic [4:0]
	{
		FPM_STANDBY  = 5'h01,
		FPM_ENTERING = 5'h02,
		FPM_SLEEP    = 5'h04,
		FPM_WAKING   = 5'h08,
		FPM_ACTIVE   = 5'h10
	} fpm_mode_t;

	typedef struct packed
	{
		logic       valid;
		logic [7:0] code;
	} fpm_cmd_t;
endpackage

// ==== verification/fpm_host_model.sv ====
`timescale 1ns/1ns
// spi host stand-in: clock parks low and data flips once select is released
module fpm_host_model
(
	input  wire logic clock,
	output logic      chip_select_n,
	output logic      serial_clock,
	output logic      serial_data_in
);
	initial
	begin
		chip_select_n = 1'b1;
		serial_clock = 1'b0;
		serial_data_in = 1'b0;
	end

	task automatic half();
		repeat (8) @(posedge clock);
	endtask

	// nbits msb first; odd counts exist to provoke refusals
	task automatic frame(input logic [7:0] code, input int nbits);
		@(posedge clock);
		chip_select_n <= 1'b0;
		half();
		for (int i = 0; i < nbits; i++)
		begin
			serial_data_in <= code[7 - (i % 8)];
			half();
			serial_clock <= 1'b1;
			half();
			serial_clock <= 1'b0;
		end
		half();
		chip_select_n <= 1'b1;
		serial_data_in <= ~serial_data_in;
		@(posedge clock);
	endtask
endmodule

// ==== verification/fpm_power_ctrl_tb.sv ====
`timescale 1ns/1ns
`define CHK(got, exp) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("Error at %0t: got %0h expected %0h", $time, got, exp); \
		end \
	end
module fpm_power_ctrl_tb;
	import fpm_pkg::*;
	localparam int INH = 200;
	localparam int ENT = 20;
	localparam int WAK = 30;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       cycle_start = 1'b0, cycle_done = 1'b0;
	logic       write_latch_set = 1'b0, write_latch_clear = 1'b0;
	logic       chip_select_n, serial_clock, serial_data_in, deep_sleep, standby;
	logic       write_inhibit, write_class_ok, cmd_accept, cycle_active_flag;
	logic       write_enable_latch;
	logic [7:0] status_byte, erased_value, c;
	logic [7:0] wcl [5] = '{FPM_CMD_SET_LATCH, FPM_CMD_REWRITE, FPM_CMD_BURN,
		FPM_CMD_PG_CLEAR, FPM_CMD_SEC_CLEAR};
	int         error_cnt, check_count, acc_n, wc_n, cyc, t0, n, a0, w0;
	integer     seed = 32'h84551781;

	always #5 clock = ~clock;
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		acc_n <= acc_n + int'(cmd_accept === 1'b1);
		wc_n <= wc_n + int'(write_class_ok === 1'b1);
	end

	fpm_host_model u_host (.clock(clock), .chip_select_n(chip_select_n),
		.serial_clock(serial_clock), .serial_data_in(serial_data_in));
	fpm_power_ctrl #(.INHIBIT_CYC(INH), .ENTRY_CYC(ENT), .WAKE_CYC(WAK)) u_fpm_power_ctrl (
		.clock(clock), .rst(rst), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
		.serial_data_in(serial_data_in), .cycle_start(cycle_start), .cycle_done(cycle_done),
		.write_latch_set(write_latch_set), .write_latch_clear(write_latch_clear),
		.deep_sleep(deep_sleep), .standby(standby), .write_inhibit(write_inhibit),
		.write_class_ok(write_class_ok), .cmd_accept(cmd_accept), .status_byte(status_byte),
		.erased_value(erased_value), .cycle_active_flag(cycle_active_flag),
		.write_enable_latch(write_enable_latch));

	function automatic logic is_wc(logic [7:0] k);
		return k inside {FPM_CMD_SET_LATCH, FPM_CMD_REWRITE, FPM_CMD_BURN,
			FPM_CMD_PG_CLEAR, FPM_CMD_SEC_CLEAR};
	endfunction

	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// 0 start, 1 done, 2 latch set, 3 latch clear
	task automatic pulse(input int which);
		@(posedge clock);
		case (which)
			0: cycle_start <= 1'b1;
			1: cycle_done <= 1'b1;
			2: write_latch_set <= 1'b1;
			default: write_latch_clear <= 1'b1;
		endcase
		@(posedge clock);
		{cycle_start, cycle_done, write_latch_set, write_latch_clear} <= 4'h0;
		@(negedge clock);
	endtask

	// the extra cycles cover the select synchroniser and the answer pulse
	task automatic send(input logic [7:0] k, input int nb);
		u_host.frame(k, nb);
		repeat (8) @(negedge clock);
	endtask

	// 0 deep_sleep, 1 standby, 2 write_inhibit
	task automatic wait_for(input int which, input logic v, input int lim);
		n = 0;
		while (((which == 0) ? deep_sleep : (which == 1) ? standby : write_inhibit) !== v)
		begin
			@(negedge clock);
			n++;
			if (n > lim)
			begin
				error_cnt++;
				$display("Error at %0t: wait ran out", $time);
				wrap_up();
			end
		end
	endtask

	initial
	begin
		repeat (8) @(negedge clock);
		`CHK(deep_sleep, 1'b0);
		`CHK(write_inhibit, 1'b1);
		`CHK(status_byte, 8'h00);
		`CHK(erased_value, 8'hFF);
		@(posedge clock);
		rst <= 1'b0;
		t0 = cyc;
		pulse(2);
		`CHK(write_enable_latch, 1'b0);
		send(FPM_CMD_SET_LATCH, 8);
		`CHK(wc_n, 0);
		wait_for(2, 1'b0, INH);
		`CHK(cyc - t0 >= INH && cyc - t0 <= INH + 4, 1'b1);
		`CHK(standby, 1'b1);
		for (int i = 0; i < 10; i++)
		begin
			c = (i < 5) ? wcl[i] : 8'($random(seed));
			if (c == FPM_CMD_SLEEP_DEF || c == FPM_CMD_WAKE_DEF)
				c = c ^ 8'h01;
			a0 = acc_n;
			w0 = wc_n;
			send(c, 8);
			`CHK(acc_n, a0 + 1);
			`CHK(wc_n, w0 + int'(is_wc(c)));
			`CHK(deep_sleep, 1'b0);
		end
		for (int nb = 7; nb <= 9; nb += 2)
		begin
			a0 = acc_n;
			send(FPM_CMD_SLEEP_DEF, nb);
			repeat (ENT + 4) @(negedge clock);
			`CHK(deep_sleep, 1'b0);
			`CHK(acc_n, a0);
		end
		pulse(0);
		`CHK(status_byte, 8'h01);
		`CHK(standby, 1'b0);
		send(FPM_CMD_SLEEP_DEF, 8);
		repeat (ENT + 4) @(negedge clock);
		`CHK(deep_sleep, 1'b0);
		`CHK(cycle_active_flag, 1'b1);
		pulse(1);
		`CHK(cycle_active_flag, 1'b0);
		pulse(2);
		`CHK(status_byte, 8'h02);
		pulse(3);
		`CHK(write_enable_latch, 1'b0);
		pulse(2);
		send(FPM_CMD_SLEEP_DEF, 8);
		wait_for(0, 1'b1, ENT + 8);
		`CHK(n >= ENT - 8 && n <= ENT, 1'b1);
		a0 = acc_n;
		w0 = wc_n;
		send(FPM_CMD_SET_LATCH, 8);
		`CHK(acc_n + wc_n, a0 + w0);
		send(FPM_CMD_WAKE_DEF, 9);
		repeat (WAK + 8) @(negedge clock);
		`CHK(deep_sleep, 1'b1);
		send(FPM_CMD_WAKE_DEF, 8);
		wait_for(1, 1'b1, WAK + 8);
		`CHK(n >= WAK - 8 && n <= WAK, 1'b1);
		send(FPM_CMD_SLEEP_DEF, 8);
		wait_for(0, 1'b1, ENT + 8);
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		`CHK({deep_sleep, standby, write_enable_latch}, 3'b010);
		wrap_up();
	end
endmodule
